// [pkg/cbi_map.vh]
// Constants for the control byte interpreter: control byte fields,
// block check types and reset values.
// Assumes inclusion by bare name from files under src/ and sim/.
`ifndef CBI_MAP_VH
`define CBI_MAP_VH

// Control byte fields
`define CBI_C_INT      0
`define CBI_C_DLE      1
`define CBI_C_BCC      2
`define CBI_C_INC      3
`define CBI_C_DIS      4
`define CBI_C_MODE_LO  5
`define CBI_C_MODE_HI  7

// Direction of a request
`define CBI_DIR_TX     1'b0
`define CBI_DIR_RX     1'b1

// Block check types
`define CBI_BCC_LRC    2'h0
`define CBI_BCC_CRC16  2'h1
`define CBI_BCC_CCITT  2'h2

// Reflected CRC polynomials
`define CBI_POLY_CRC16 16'hA001
`define CBI_POLY_CCITT 16'h8408

// Reset values
`define CBI_ACC_RST    16'h0000
`define CBI_MODE_RST   3'h0
`define CBI_CHAR_RST   8'h00

`endif

// [src/cbi_fifo.v]
// Synchronous FIFO with a registered output stage.
// Assumes one clock, synchronous active-high reset and a clock enable.
`timescale 1ns/100ps
`default_nettype none

module cbi_fifo #(
    parameter WIDTH = 12,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // Clock and reset
    input  wire             sys_clk,
    input  wire             rst,
    input  wire             ce,
    // Fill side
    input  wire             in_valid,
    output reg              in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Drain side
    output reg              out_valid,
    input  wire             out_ready,
    output reg  [WIDTH-1:0] out_data
);

    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [AW-1:0]    wp;
    reg  [AW-1:0]    rp;
    reg  [AW:0]      cnt;

    wire             push = in_valid & in_ready;
    wire             load = (cnt != {(AW+1){1'b0}}) & (~out_valid | out_ready);
    wire [AW:0]      next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};

    always @(posedge sys_clk) begin
        if (rst) begin
            wp        <= {AW{1'b0}};
            rp        <= {AW{1'b0}};
            cnt       <= {(AW+1){1'b0}};
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
            out_data  <= {WIDTH{1'b0}};
        end else if (ce) begin
            if (push) begin
                mem[wp] <= in_data;
                wp      <= wp + {{(AW-1){1'b0}}, 1'b1};
            end
            if (load) begin
                out_data  <= mem[rp];
                out_valid <= 1'b1;
                rp        <= rp + {{(AW-1){1'b0}}, 1'b1};
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
            cnt      <= next_cnt;
            // Registered full: refuses one entry early is avoided by exact count
            in_ready <= (next_cnt < DEPTH[AW:0]);
        end
    end

endmodule

`default_nettype wire

// [src/cbi_interp.v]
// Per-character control byte interpreter for a multi-line synchronous
// multiplexer: DLE insertion, block check send/expect, store or discard,
// host interrupt and mode sequencing.
// Assumes the requester fetches each control byte from the line's table
// using mode_out, and holds a request until req_ack.
`timescale 1ns/100ps
`default_nettype none
`include "cbi_map.vh"

module cbi_interp #(
    parameter LINES = 16,
    parameter LW    = 4,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // Clock, reset, enable
    input  wire          sys_clk,
    input  wire          rst,
    input  wire          ce,
    // Character request
    input  wire          req_valid,
    input  wire          req_dir,
    input  wire [LW-1:0] req_line,
    input  wire [7:0]    req_char,
    input  wire [7:0]    req_ctrl,
    input  wire [7:0]    req_dle,
    input  wire [1:0]    req_bcc_type,
    output reg           req_ack,
    // Mode lookup for table indexing
    input  wire [LW-1:0] mode_line,
    input  wire          mode_dir,
    output reg  [2:0]    mode_out,
    // Receive store to memory
    output reg           store_valid,
    output reg  [LW-1:0] store_line,
    output reg  [7:0]    store_char,
    // Received block check result
    output reg           bcc_done,
    output reg           bcc_err,
    output reg  [LW-1:0] bcc_line,
    // Host interrupt and system control bit 08
    output reg           receive_interrupt_pending_bit,
    output reg  [LW-1:0] int_line,
    output reg  [7:0]    int_char,
    input  wire          int_clear,
    // Transmit character stream
    output wire          tx_valid,
    input  wire          tx_ready,
    output wire [LW+7:0] tx_data
);

    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_DLE  = 6'h02;
    localparam [5:0] ST_CHR  = 6'h04;
    localparam [5:0] ST_BC1  = 6'h08;
    localparam [5:0] ST_BC2  = 6'h10;
    localparam [5:0] ST_ACK  = 6'h20;

    // Byte-wise CRC, reflected form
    function [15:0] crc_byte;
        input [15:0] acc;
        input [7:0]  data;
        input [15:0] poly;
        integer      k;
        reg   [15:0] c;
        begin
            c = acc ^ {8'h00, data};
            for (k = 0; k < 8; k = k + 1) begin
                if (c[0])
                    c = (c >> 1) ^ poly;
                else
                    c = c >> 1;
            end
            crc_byte = c;
        end
    endfunction

    // Fold one character by the selected check type
    function [15:0] bcc_fold;
        input [15:0] acc;
        input [7:0]  data;
        input [1:0]  kind;
        begin
            case (kind)
                `CBI_BCC_CRC16: bcc_fold = crc_byte(acc, data, `CBI_POLY_CRC16);
                `CBI_BCC_CCITT: bcc_fold = crc_byte(acc, data, `CBI_POLY_CCITT);
                default:        bcc_fold = {8'h00, acc[7:0] ^ data};
            endcase
        end
    endfunction

    function is_crc;
        input [1:0] kind;
        begin
            is_crc = (kind == `CBI_BCC_CRC16) || (kind == `CBI_BCC_CCITT);
        end
    endfunction

    // Per-line, per-direction state
    reg  [2:0]       tx_mode [0:LINES-1];
    reg  [2:0]       rx_mode [0:LINES-1];
    reg  [15:0]      tx_acc  [0:LINES-1];
    reg  [15:0]      rx_acc  [0:LINES-1];
    reg  [LINES-1:0] rx_exp1;
    reg  [LINES-1:0] rx_exp2;
    reg  [LINES-1:0] rx_stall;

    reg  [5:0]       state;
    reg  [LW-1:0]    t_line;
    reg  [7:0]       t_char;
    reg  [7:0]       t_ctrl;
    reg  [7:0]       t_dle;
    reg  [1:0]       t_type;

    reg              f_valid;
    reg  [7:0]       f_byte;
    wire             f_ready;
    wire             f_push = f_valid & f_ready;

    wire             take = req_valid & (state == ST_IDLE) &
                            ~((req_dir == `CBI_DIR_RX) & rx_stall[req_line]);
    wire [15:0]      r_acc = rx_acc[req_line];
    wire [15:0]      t_acc = tx_acc[t_line];
    integer          i;

    // Byte offered to the transmit FIFO in each state
    always @* begin
        f_valid = 1'b0;
        f_byte  = t_char;
        case (state)
            ST_DLE: begin
                f_valid = 1'b1;
                f_byte  = t_dle;
            end
            ST_CHR: begin
                f_valid = 1'b1;
                f_byte  = t_char;
            end
            ST_BC1: begin
                f_valid = 1'b1;
                f_byte  = t_acc[7:0];
            end
            ST_BC2: begin
                f_valid = 1'b1;
                f_byte  = t_acc[15:8];
            end
            default: begin
                f_valid = 1'b0;
                f_byte  = t_char;
            end
        endcase
    end

    // Back-pressure from the FIFO stalls the transmit sequence
    cbi_fifo #(
        .WIDTH (LW + 8),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .ce        (ce),
        .in_valid  (f_valid),
        .in_ready  (f_ready),
        .in_data   ({t_line, f_byte}),
        .out_valid (tx_valid),
        .out_ready (tx_ready),
        .out_data  (tx_data)
    );

    always @(posedge sys_clk) begin
        if (rst) begin
            state       <= ST_IDLE;
            t_line      <= {LW{1'b0}};
            t_char      <= `CBI_CHAR_RST;
            t_ctrl      <= `CBI_CHAR_RST;
            t_dle       <= `CBI_CHAR_RST;
            t_type      <= `CBI_BCC_LRC;
            req_ack     <= 1'b0;
            mode_out    <= `CBI_MODE_RST;
            store_valid <= 1'b0;
            store_line  <= {LW{1'b0}};
            store_char  <= `CBI_CHAR_RST;
            bcc_done    <= 1'b0;
            bcc_err     <= 1'b0;
            bcc_line    <= {LW{1'b0}};
            int_line    <= {LW{1'b0}};
            int_char    <= `CBI_CHAR_RST;
            receive_interrupt_pending_bit <= 1'b0;
            rx_exp1     <= {LINES{1'b0}};
            rx_exp2     <= {LINES{1'b0}};
            rx_stall    <= {LINES{1'b0}};
            for (i = 0; i < LINES; i = i + 1) begin
                tx_mode[i] <= `CBI_MODE_RST;
                rx_mode[i] <= `CBI_MODE_RST;
                tx_acc[i]  <= `CBI_ACC_RST;
                rx_acc[i]  <= `CBI_ACC_RST;
            end
        end else if (ce) begin
            req_ack     <= 1'b0;
            store_valid <= 1'b0;
            bcc_done    <= 1'b0;
            // Current mode lets the requester index the right table
            mode_out    <= (mode_dir == `CBI_DIR_RX) ? rx_mode[mode_line] : tx_mode[mode_line];

            // Host clear releases every stalled line; a new request below wins
            if (int_clear) begin
                receive_interrupt_pending_bit <= 1'b0;
                rx_stall <= {LINES{1'b0}};
            end

            case (state)
                ST_IDLE: begin
                    if (take && req_dir == `CBI_DIR_TX) begin
                        t_line <= req_line;
                        t_char <= req_char;
                        t_ctrl <= req_ctrl;
                        t_dle  <= req_dle;
                        t_type <= req_bcc_type;
                        // Bits 00 and 04 never read on transmit
                        state  <= req_ctrl[`CBI_C_DLE] ? ST_DLE : ST_CHR;
                    end else if (take) begin
                        state   <= ST_ACK;
                        req_ack <= 1'b1;
                        if (rx_exp2[req_line]) begin
                            // Second check character closes the frame
                            rx_exp2[req_line] <= 1'b0;
                            rx_acc[req_line]  <= `CBI_ACC_RST;
                            bcc_done <= 1'b1;
                            bcc_line <= req_line;
                            bcc_err  <= (req_char != r_acc[15:8]);
                        end else if (rx_exp1[req_line]) begin
                            // First check character, never stored
                            rx_exp1[req_line] <= 1'b0;
                            bcc_line <= req_line;
                            if (is_crc(req_bcc_type) && req_char == r_acc[7:0]) begin
                                rx_exp2[req_line] <= 1'b1;
                            end else begin
                                rx_acc[req_line] <= `CBI_ACC_RST;
                                bcc_done <= 1'b1;
                                bcc_err  <= (req_char != r_acc[7:0]);
                            end
                        end else begin
                            // Bit 01 never read on receive
                            if (req_ctrl[`CBI_C_INC])
                                rx_acc[req_line] <= bcc_fold(r_acc, req_char, req_bcc_type);
                            if (!req_ctrl[`CBI_C_DIS]) begin
                                store_valid <= 1'b1;
                                store_line  <= req_line;
                                store_char  <= req_char;
                            end
                            // Discard set: no store pulse at all
                            if (req_ctrl[`CBI_C_BCC])
                                rx_exp1[req_line] <= 1'b1;
                            if (req_ctrl[`CBI_C_INT]) begin
                                receive_interrupt_pending_bit <= 1'b1;
                                rx_stall[req_line] <= 1'b1;
                                int_line <= req_line;
                                int_char <= req_char;
                            end
                            // Per-line receive mode for the next character
                            rx_mode[req_line] <= req_ctrl[`CBI_C_MODE_HI:`CBI_C_MODE_LO];
                        end
                    end
                end
                ST_DLE: begin
                    if (f_push)
                        state <= ST_CHR;
                end
                ST_CHR: begin
                    if (f_push) begin
                        if (t_ctrl[`CBI_C_INC])
                            tx_acc[t_line] <= bcc_fold(t_acc, t_char, t_type);
                        if (t_ctrl[`CBI_C_BCC]) begin
                            state <= ST_BC1;
                        end else begin
                            state   <= ST_ACK;
                            req_ack <= 1'b1;
                            tx_mode[t_line] <= t_ctrl[`CBI_C_MODE_HI:`CBI_C_MODE_LO];
                        end
                    end
                end
                ST_BC1: begin
                    if (f_push) begin
                        if (is_crc(t_type)) begin
                            state <= ST_BC2;
                        end else begin
                            state   <= ST_ACK;
                            req_ack <= 1'b1;
                            tx_acc[t_line]  <= `CBI_ACC_RST;
                            tx_mode[t_line] <= t_ctrl[`CBI_C_MODE_HI:`CBI_C_MODE_LO];
                        end
                    end
                end
                ST_BC2: begin
                    if (f_push) begin
                        state   <= ST_ACK;
                        req_ack <= 1'b1;
                        tx_acc[t_line]  <= `CBI_ACC_RST;
                        tx_mode[t_line] <= t_ctrl[`CBI_C_MODE_HI:`CBI_C_MODE_LO];
                    end
                end
                ST_ACK: begin
                    // One idle cycle so a held request is not taken twice
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// [sim/cbi_interp_monitor.sv]
// Concurrent checks on the ports of the control byte interpreter.
// Assumes one clock, sys_clk, and synchronous active-high rst.
`timescale 1ns/100ps
`default_nettype none

module cbi_interp_monitor #(
    parameter LINES = 16,
    parameter LW    = 4,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // Clock and reset
    input wire logic          sys_clk,
    input wire logic          rst,
    // Request side
    input wire logic          req_valid,
    input wire logic          req_dir,
    input wire logic [LW-1:0] req_line,
    input wire logic [7:0]    req_char,
    input wire logic [7:0]    req_ctrl,
    input wire logic          req_ack,
    // Receive results
    input wire logic          store_valid,
    input wire logic [LW-1:0] store_line,
    input wire logic [7:0]    store_char,
    input wire logic          bcc_done,
    // Interrupt
    input wire logic          receive_interrupt_pending_bit,
    input wire logic [LW-1:0] int_line,
    input wire logic [7:0]    int_char,
    input wire logic          int_clear,
    // Transmit stream
    input wire logic          tx_valid,
    input wire logic          tx_ready,
    input wire logic [LW+7:0] tx_data
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    reset_clear_a: assert property ($fell(rst) |-> !tx_valid && !req_ack && !receive_interrupt_pending_bit)
        else $error("outputs not clear after reset");
    ack_needs_req_a: assert property (req_ack |-> $past(req_valid) && !$past(req_ack))
        else $error("ack without a held request");
    store_rx_a: assert property (store_valid |-> req_ack && $past(req_dir) && !$past(req_ctrl[4])
        && store_char == $past(req_char) && store_line == $past(req_line))
        else $error("store does not match the request");
    discard_a: assert property (req_ack && $past(req_dir) && $past(req_ctrl[4]) |-> !store_valid)
        else $error("discarded character stored");
    int_sets_a: assert property (req_ack && $past(req_dir) && $past(req_ctrl[0]) && !bcc_done
        |-> receive_interrupt_pending_bit && int_char == $past(req_char) && int_line == $past(req_line))
        else $error("interrupt character not captured");
    int_holds_a: assert property (receive_interrupt_pending_bit && !int_clear |=> receive_interrupt_pending_bit)
        else $error("interrupt bit dropped without clear");
    line_stall_a: assert property (receive_interrupt_pending_bit && req_valid && req_dir && req_line == int_line
        && !int_clear && !req_ack |=> !req_ack)
        else $error("stalled line answered");
    tx_ignore_a: assert property (req_ack && !$past(req_dir) && $past(req_ctrl[0])
        |-> !$rose(receive_interrupt_pending_bit) && !store_valid)
        else $error("transmit byte acted on unused bits");
    bcc_with_ack_a: assert property (bcc_done |-> req_ack && $past(req_dir))
        else $error("check result outside a receive answer");
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("transmit word lost while stalled");
endmodule

bind cbi_interp cbi_interp_monitor #(.LINES(LINES), .LW(LW), .DEPTH(DEPTH), .AW(AW)) chk (
    .sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req_dir(req_dir), .req_line(req_line),
    .req_char(req_char), .req_ctrl(req_ctrl), .req_ack(req_ack), .store_valid(store_valid),
    .store_line(store_line), .store_char(store_char), .bcc_done(bcc_done),
    .receive_interrupt_pending_bit(receive_interrupt_pending_bit), .int_line(int_line),
    .int_char(int_char), .int_clear(int_clear), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));
`default_nettype wire

// [sim/cbi_host.sv]
// Host side model: drains the transmit stream and clears the interrupt bit.
// Assumes the bench clock; controls change on the falling edge.
`timescale 1ns/100ps
`default_nettype none

module cbi_host (
    // Clock
    input  wire logic        sys_clk,
    // Host controls
    input  wire logic        stall,
    input  wire logic        allow_clear,
    // Transmit stream
    input  wire logic        tx_valid,
    input  wire logic [11:0] tx_data,
    output var  logic        tx_ready,
    // Interrupt bit
    input  wire logic        receive_interrupt_pending_bit,
    output var  logic        int_clear
);
    logic [11:0] got [0:63];
    integer      n_got = 0;

    always @(posedge sys_clk) begin
        if (tx_valid && tx_ready) begin
            got[n_got] = tx_data;
            n_got = n_got + 1;
        end
    end
    // One-cycle clear, only while the bench holds allow_clear high
    always @(negedge sys_clk) begin
        tx_ready <= !stall;
        int_clear <= receive_interrupt_pending_bit && allow_clear && !int_clear;
    end
endmodule
`default_nettype wire

// [sim/cbi_interp_bench.sv]
// Self-checking bench for the control byte interpreter.
// Assumes cbi_interp with 16 lines, the host model and the bound monitor.
`timescale 1ns/100ps
`default_nettype none
`include "cbi_map.vh"

module cbi_interp_bench;
    logic        sys_clk;
    logic        rst = 1'b1;
    logic        req_valid = 1'b0;
    logic        req_dir = 1'b0;
    logic [3:0]  req_line = 4'h0;
    logic [7:0]  req_char = 8'h00;
    logic [7:0]  req_ctrl = 8'h00;
    logic [1:0]  req_bcc_type = 2'h0;
    logic [3:0]  mode_line = 4'h0;
    logic        mode_dir = 1'b0;
    logic        stall = 1'b0;
    logic        allow_clear = 1'b0;
    logic        ce = 1'b1;
    logic [7:0]  req_dle = 8'h10;
    wire         req_ack, store_valid, bcc_done, bcc_err, receive_interrupt_pending_bit;
    wire         int_clear, tx_valid, tx_ready;
    wire  [3:0]  store_line, bcc_line, int_line;
    wire  [7:0]  store_char, int_char;
    wire  [2:0]  mode_out;
    wire  [11:0] tx_data;
    logic        ok, sv, bd, be;
    logic [7:0]  sc;
    integer      err_total = 0;
    integer      num_checks = 0;
    integer      tx_idx = 0;

    cbi_interp uut (
        .sys_clk(sys_clk), .rst(rst), .ce(ce), .req_valid(req_valid), .req_dir(req_dir),
        .req_line(req_line), .req_char(req_char), .req_ctrl(req_ctrl), .req_dle(req_dle),
        .req_bcc_type(req_bcc_type), .req_ack(req_ack), .mode_line(mode_line), .mode_dir(mode_dir),
        .mode_out(mode_out), .store_valid(store_valid), .store_line(store_line), .store_char(store_char),
        .bcc_done(bcc_done), .bcc_err(bcc_err), .bcc_line(bcc_line),
        .receive_interrupt_pending_bit(receive_interrupt_pending_bit), .int_line(int_line),
        .int_char(int_char), .int_clear(int_clear), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));
    cbi_host host (
        .sys_clk(sys_clk), .stall(stall), .allow_clear(allow_clear), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .receive_interrupt_pending_bit(receive_interrupt_pending_bit), .int_clear(int_clear));

    function [15:0] crc16(input [15:0] a, input [7:0] b, input [15:0] p);
        integer i;
        begin
            crc16 = a;
            for (i = 0; i < 8; i = i + 1)
                crc16 = (crc16[0] ^ b[i]) ? ((crc16 >> 1) ^ p) : (crc16 >> 1);
        end
    endfunction
    task check(input [15:0] seen, input [15:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wait_ack(input integer lim);
        integer i;
        begin
            ok = 1'b0;
            for (i = 0; i < lim && !ok; i = i + 1) begin
                @(negedge sys_clk);
                ok = (req_ack === 1'b1);
            end
            if (ok) begin
                req_valid = 1'b0;
                sv = store_valid;
                sc = store_char;
                bd = bcc_done;
                be = bcc_err;
            end
        end
    endtask
    // Each request carries its own direction's control byte
    task send(input d, input [3:0] l, input [7:0] c, input [7:0] k, input [1:0] t, input integer lim);
        begin
            @(negedge sys_clk);
            req_dir = d;
            req_line = l;
            req_char = c;
            req_ctrl = k;
            req_bcc_type = t;
            req_dle = {4'h9, l};
            req_valid = 1'b1;
            wait_ack(lim);
        end
    endtask
    task tx_exp(input [3:0] l, input [7:0] b);
        begin
            check({4'h0, host.got[tx_idx]}, {4'h0, l, b});
            tx_idx = tx_idx + 1;
        end
    endtask
    task drain(input integer n);
        integer i;
        begin
            for (i = 0; i < 100 && host.n_got < n; i = i + 1)
                @(negedge sys_clk);
        end
    endtask
    task mode_is(input [3:0] l, input d, input [2:0] m);
        begin
            @(negedge sys_clk);
            mode_line = l;
            mode_dir = d;
            repeat (2) @(negedge sys_clk);
            check({13'h0, mode_out}, {13'h0, m});
        end
    endtask

    task t_tx_dle_lrc;
        begin
            send(1'b0, 4'h1, 8'hA1, 8'h19, 2'h0, 50);
            check({15'h0, receive_interrupt_pending_bit}, 16'h0000);
            send(1'b0, 4'h1, 8'h33, 8'h00, 2'h0, 50);
            send(1'b0, 4'h1, 8'h5C, 8'h6E, 2'h0, 50);
            drain(tx_idx + 5);
            tx_exp(4'h1, 8'hA1);
            tx_exp(4'h1, 8'h33);
            tx_exp(4'h1, 8'h91);
            tx_exp(4'h1, 8'h5C);
            tx_exp(4'h1, 8'hFD);
            mode_is(4'h1, 1'b0, 3'h3);
            mode_is(4'h1, 1'b1, 3'h0);
        end
    endtask
    task t_tx_crc;
        logic [15:0] a;
        begin
            a = crc16(crc16(16'h0000, 8'h31, `CBI_POLY_CRC16), 8'h32, `CBI_POLY_CRC16);
            send(1'b0, 4'h2, 8'h31, 8'h08, 2'h1, 50);
            send(1'b0, 4'h2, 8'h32, 8'h0C, 2'h1, 50);
            drain(tx_idx + 4);
            tx_exp(4'h2, 8'h31);
            tx_exp(4'h2, 8'h32);
            tx_exp(4'h2, a[7:0]);
            tx_exp(4'h2, a[15:8]);
            a = crc16(16'h0000, 8'h31, `CBI_POLY_CCITT);
            send(1'b0, 4'h8, 8'h31, 8'h0C, 2'h2, 50);
            drain(tx_idx + 3);
            tx_exp(4'h8, 8'h31);
            tx_exp(4'h8, a[7:0]);
            tx_exp(4'h8, a[15:8]);
        end
    endtask
    task t_rx_store;
        begin
            // Enable low freezes the request in the idle state
            ce = 1'b0;
            send(1'b1, 4'h3, 8'h41, 8'hA2, 2'h0, 5);
            check({15'h0, ok}, 16'h0000);
            ce = 1'b1;
            wait_ack(20);
            check({7'h0, sv, sc}, 16'h0141);
            send(1'b1, 4'h3, 8'h42, 8'hB0, 2'h0, 20);
            check({15'h0, sv}, 16'h0000);
            check(host.n_got[15:0], tx_idx[15:0]);
            mode_is(4'h3, 1'b1, 3'h5);
            mode_is(4'h3, 1'b0, 3'h0);
        end
    endtask
    task t_rx_bcc;
        logic [15:0] a;
        begin
            send(1'b1, 4'h4, 8'h11, 8'h08, 2'h0, 20);
            send(1'b1, 4'h4, 8'h22, 8'h0C, 2'h0, 20);
            send(1'b1, 4'h4, 8'h33, 8'h00, 2'h0, 20);
            check({13'h0, sv, bd, be}, 16'h0002);
            check({12'h0, bcc_line}, 16'h0004);
            send(1'b1, 4'h4, 8'h44, 8'h0C, 2'h0, 20);
            send(1'b1, 4'h4, 8'h00, 8'h00, 2'h0, 20);
            check({13'h0, sv, bd, be}, 16'h0003);
            a = crc16(16'h0000, 8'h55, `CBI_POLY_CRC16);
            send(1'b1, 4'h5, 8'h55, 8'h0C, 2'h1, 20);
            send(1'b1, 4'h5, a[7:0], 8'h00, 2'h1, 20);
            // Error flag still stands from the last finished check
            check({13'h0, sv, bd, be}, 16'h0001);
            send(1'b1, 4'h5, a[15:8], 8'h00, 2'h1, 20);
            check({13'h0, sv, bd, be}, 16'h0002);
            check({12'h0, bcc_line}, 16'h0005);
        end
    endtask
    task t_int;
        begin
            send(1'b1, 4'h6, 8'h7E, 8'h01, 2'h0, 20);
            check({7'h0, receive_interrupt_pending_bit, int_char}, 16'h017E);
            check({12'h0, int_line}, 16'h0006);
            send(1'b1, 4'h6, 8'h01, 8'h00, 2'h0, 10);
            check({15'h0, ok}, 16'h0000);
            allow_clear = 1'b1;
            wait_ack(20);
            check({14'h0, ok, receive_interrupt_pending_bit}, 16'h0002);
            allow_clear = 1'b0;
        end
    endtask
    task t_fifo;
        integer i, n;
        begin
            stall = 1'b1;
            ok = 1'b1;
            n = 0;
            for (i = 0; i < 10 && ok; i = i + 1) begin
                send(1'b0, 4'h7, 8'h80 + i[7:0], 8'h00, 2'h0, 20);
                n = n + ok;
            end
            check(n[15:0], 16'h0009);
            stall = 1'b0;
            wait_ack(50);
            drain(tx_idx + 10);
            for (i = 0; i < 10; i = i + 1)
                tx_exp(4'h7, 8'h80 + i[7:0]);
            @(negedge sys_clk);
            check({15'h0, tx_valid}, 16'h0000);
        end
    endtask

    task end_of_test;
        begin
            $display("checks %0d errors %0d", num_checks, err_total);
            if (err_total == 0 && num_checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        t_tx_dle_lrc;
        t_tx_crc;
        t_rx_store;
        t_rx_bcc;
        t_int;
        t_fifo;
        end_of_test;
    end
    // Whole run needs about two hundred cycles
    initial begin
        #(2000000);
        err_total = err_total + 1;
        end_of_test;
    end
endmodule
`default_nettype wire
